//--- hdl/qdr_port_pkg.sv
// constants and timing figures for the quad-rate sram port
// assumes a 40 MHz system clock; the memory clock is derived from it by division
package qdr_port_pkg;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 18;
   localparam int DATA_W = 18;
   localparam int PAIR_W = 2 * DATA_W;
   localparam int WORDS_PER_WRITE = 4;
   localparam int FIFO_DEPTH = 16;

   // ----------------------------------------------------------------
   // clocking
   // ----------------------------------------------------------------
   localparam int SYS_CLK_KHZ = 40000;
   localparam int K_DIV = 8;
   localparam int MEM_CLK_KHZ = SYS_CLK_KHZ / K_DIV;
   localparam int GEN1_MAX_KHZ = 167000;
   localparam int GEN2_MAX_KHZ = 200000;
   localparam int WR_SHIFT_DEG = 90;
   localparam int WR_SHIFT_CYC = (K_DIV * WR_SHIFT_DEG) / 360;

   // ----------------------------------------------------------------
   // phase plan inside one memory clock period (8 system cycles)
   // ----------------------------------------------------------------
   localparam logic [2:0] PH_K_FALL = 3'h4;
   localparam logic [2:0] PH_DECIDE = 3'h4;
   localparam logic [2:0] PH_LAUNCH_A = 3'(K_DIV - WR_SHIFT_CYC - 1);
   localparam logic [2:0] PH_LAUNCH_B = 3'(K_DIV / 2 - WR_SHIFT_CYC - 1);
   localparam logic [2:0] PH_LAST = 3'(K_DIV - 1);

   // ----------------------------------------------------------------
   // read return
   // ----------------------------------------------------------------
   localparam int RD_LAT_EDGES = 2;
   localparam logic [4:0] PAIRS_B2 = 5'h01;
   localparam logic [4:0] PAIRS_B4 = 5'h02;
   localparam logic [5:0] FIFO_ROOM = 6'h10;
endpackage : qdr_port_pkg

//--- hdl/pair_fifo.sv
// synchronous first-in first-out buffer with valid/ready on both sides
// assumes depth is a power of two; single clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module pair_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 16
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out,
   output logic [$clog2(DEPTH+1)-1:0] level_out
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   localparam logic [CW-1:0] FULL_LEVEL = CW'(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [CW-1:0] count;

   wire logic do_push = in_valid_in && in_ready_out;
   wire logic do_pop = out_valid_out && out_ready_in;

   assign in_ready_out = (count != FULL_LEVEL);
   assign out_valid_out = (count != '0);
   assign out_data_out = store[rd_ptr];
   assign level_out = count;

   always_ff @(posedge clk_in) begin
      if (do_push) begin
         store[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + CW'(do_push) - CW'(do_pop);
      end
   end
endmodule : pair_fifo
`default_nettype wire

//--- hdl/quad_rate_sram_port.sv
// controller end of a quad-rate sram link: clock pairs, address, selects, write data out,
// echo-clocked read capture in, read pairs handed to user logic through a fifo
// assumes mode inputs are static while traffic is in flight; memory pins are outside this clock
//
// Summary of operation
// - separate one-way read and write data buses, one shared address bus
// - burst-of-two: read address at K rise, write address at Kn rise
// - burst-of-four: read and write addresses both captured at K rise
// - both burst lengths supported, up to four words per memory cycle
// - Kn and Cn driven as exact inverses of K and C; CQn inverse of CQ
// - controller drives C, Cn, K, Kn; memory returns echo clocks CQ, CQn
// - single-clock mode: K/Kn time everything, C/Cn unused
// - multi-clock mode: drive both C/Cn and K/Kn pairs
// - read data captured with the edge-aligned echo clocks
// - write data launched a quarter period before K edge, centred in eye
// - memory clocks come from output registers, not routed core clocks
// - read bus, write bus and clock outputs all in dedicated pad registers
// - first generation at most 167 MHz, second generation at most 200 MHz
// - burst-of-two: read and write may be issued in the same cycle, no turnaround; burst-of-four alternates them
`timescale 1ns/1ps
`default_nettype none
module quad_rate_sram_port
   import qdr_port_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic burst4_mode_in,
   input wire logic multi_clock_in,
   input wire logic gen2_in,
   input wire logic rd_req_in,
   input wire logic [ADDR_W-1:0] rd_addr_in,
   output logic rd_ack_out,
   input wire logic wr_req_in,
   input wire logic [ADDR_W-1:0] wr_addr_in,
   input wire logic [WORDS_PER_WRITE*DATA_W-1:0] wr_data_in,
   output logic wr_ack_out,
   output logic [PAIR_W-1:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   output logic [ADDR_W-1:0] mem_addr_out,
   output logic mem_rd_sel_n_out,
   output logic mem_wr_sel_n_out,
   output logic [DATA_W-1:0] mem_d_out,
   output logic mem_k_out,
   output logic mem_k_n_out,
   output logic mem_c_out,
   output logic mem_c_n_out,
   input wire logic [DATA_W-1:0] mem_q_in,
   input wire logic mem_cq_in,
   input wire logic mem_cq_n_in
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [2:0] phase;
   logic slot;
   logic burst4;
   logic multi;
   logic gen2;
   logic op_rd;
   logic op_wr;
   logic wr_tail;
   logic [ADDR_W-1:0] rd_addr_hold;
   logic [ADDR_W-1:0] wr_addr_hold;
   logic [WORDS_PER_WRITE*DATA_W-1:0] wr_hold;
   logic [4:0] pending;
   logic [1:0] launch_cnt;
   logic [RD_LAT_EDGES-1:0] rd_pipe;
   logic word_live;
   logic cq_s1, cq_s2, cq_s3;
   logic cqn_s1, cqn_s2, cqn_s3;
   logic [DATA_W-1:0] q_s1, q_s2;
   logic cap_rise;
   logic cap_fall;
   logic have_lo;
   logic [DATA_W-1:0] lo_word;
   logic push_valid;
   logic [PAIR_W-1:0] push_data;

   wire logic fifo_in_ready;
   wire logic fifo_out_valid;
   wire logic [PAIR_W-1:0] fifo_out_data;
   wire logic [4:0] fifo_level;

   function automatic logic [DATA_W-1:0] word_of(input logic [WORDS_PER_WRITE*DATA_W-1:0] bundle,
                                                   input int idx);
      word_of = bundle[idx*DATA_W +: DATA_W];
   endfunction : word_of

   // ----------------------------------------------------------------
   // phase decode and issue decisions
   // ----------------------------------------------------------------
   wire logic [2:0] next_phase = phase + 3'h1;
   wire logic decide = (phase == PH_DECIDE);
   wire logic launch_a = (phase == PH_LAUNCH_A);
   wire logic launch_b = (phase == PH_LAUNCH_B);
   wire logic k_edge_next = (phase == PH_LAST);
   wire logic upcoming_slot = ~slot;
   wire logic [4:0] rd_pairs = burst4 ? PAIRS_B4 : PAIRS_B2;
   wire logic [5:0] committed = {1'b0, fifo_level} + {1'b0, pending} + {1'b0, rd_pairs};
   wire logic rd_room = (committed <= FIFO_ROOM);
   // burst-of-four alternates: reads start on even memory cycles, writes on odd ones
   wire logic rd_slot_ok = !burst4 || !upcoming_slot;
   wire logic wr_slot_ok = !burst4 || upcoming_slot;
   wire logic take_rd = decide && rd_req_in && rd_room && rd_slot_ok;
   wire logic take_wr = decide && wr_req_in && wr_slot_ok;
   wire logic idle = (pending == '0) && !op_rd && !op_wr && !wr_tail && (launch_cnt == '0);
   wire logic k_next = (next_phase < PH_K_FALL);

   // ----------------------------------------------------------------
   // launch selection
   // ----------------------------------------------------------------
   wire logic [DATA_W-1:0] beat_a = wr_tail ? word_of(wr_hold, 2) : word_of(wr_hold, 0);
   wire logic [DATA_W-1:0] beat_b = wr_tail ? word_of(wr_hold, 3) : word_of(wr_hold, 1);
   wire logic [ADDR_W-1:0] addr_a = op_rd ? rd_addr_hold : ((burst4 && op_wr) ? wr_addr_hold : mem_addr_out);
   wire logic [ADDR_W-1:0] addr_b = (!burst4 && op_wr) ? wr_addr_hold : mem_addr_out;

   // ----------------------------------------------------------------
   // memory clock generator
   // ----------------------------------------------------------------
   // clocks are flops on the pad side, so they track the data flops over voltage and temperature
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         // one step before K rise, so the first K high after reset lasts four cycles
         phase <= PH_LAST;
         slot <= 1'b0;
         mem_k_out <= 1'b0;
         mem_k_n_out <= 1'b1;
         mem_c_out <= 1'b0;
         mem_c_n_out <= 1'b1;
      end else begin
         phase <= next_phase;
         if (k_edge_next) begin
            slot <= upcoming_slot;
         end
         mem_k_out <= k_next;
         mem_k_n_out <= ~k_next;
         mem_c_out <= multi & k_next;
         mem_c_n_out <= ~(multi & k_next);
      end
   end

   // ----------------------------------------------------------------
   // mode latch
   // ----------------------------------------------------------------
   // modes only change between transfers, so a half-finished burst never switches shape
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         burst4 <= 1'b0;
         multi <= 1'b0;
         gen2 <= 1'b0;
      end else if (decide && idle) begin
         burst4 <= burst4_mode_in;
         multi <= multi_clock_in;
         gen2 <= gen2_in;
      end
   end

   // ----------------------------------------------------------------
   // command capture
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         op_rd <= 1'b0;
         op_wr <= 1'b0;
         wr_tail <= 1'b0;
         rd_addr_hold <= '0;
         wr_addr_hold <= '0;
         wr_hold <= '0;
         rd_ack_out <= 1'b0;
         wr_ack_out <= 1'b0;
      end else begin
         rd_ack_out <= take_rd;
         wr_ack_out <= take_wr;
         if (decide) begin
            op_rd <= take_rd;
            op_wr <= take_wr;
            wr_tail <= burst4 && op_wr;
         end
         if (take_rd) begin
            rd_addr_hold <= rd_addr_in;
         end
         if (take_wr) begin
            wr_addr_hold <= wr_addr_in;
            wr_hold <= wr_data_in;
         end
      end
   end

   // ----------------------------------------------------------------
   // address, selects and write data launch
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         mem_addr_out <= '0;
         mem_rd_sel_n_out <= 1'b1;
         mem_wr_sel_n_out <= 1'b1;
         mem_d_out <= '0;
      end else if (launch_a) begin
         mem_addr_out <= addr_a;
         mem_rd_sel_n_out <= ~op_rd;
         mem_wr_sel_n_out <= ~op_wr;
         mem_d_out <= beat_a;
      end else if (launch_b) begin
         mem_addr_out <= addr_b;
         mem_d_out <= beat_b;
      end
   end

   // ----------------------------------------------------------------
   // read return synchronisers
   // ----------------------------------------------------------------
   // pins are asynchronous to this clock; the first stage feeds only the second
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         cq_s1 <= 1'b0;
         cq_s2 <= 1'b0;
         cq_s3 <= 1'b0;
         cqn_s1 <= 1'b1;
         cqn_s2 <= 1'b1;
         cqn_s3 <= 1'b1;
         q_s1 <= '0;
         q_s2 <= '0;
      end else begin
         cq_s1 <= mem_cq_in;
         cq_s2 <= cq_s1;
         cq_s3 <= cq_s2;
         cqn_s1 <= mem_cq_n_in;
         cqn_s2 <= cqn_s1;
         cqn_s3 <= cqn_s2;
         q_s1 <= mem_q_in;
         q_s2 <= q_s1;
      end
   end

   // cqn rising is the falling half of the echo pair
   wire logic cq_rise = cq_s2 & ~cq_s3;
   wire logic cqn_rise = cqn_s2 & ~cqn_s3;
   wire logic launch_any = (launch_cnt != '0);
   wire logic [RD_LAT_EDGES-1:0] pipe_shifted = {rd_pipe[RD_LAT_EDGES-2:0], launch_any};
   wire logic [1:0] launch_add = (k_edge_next && op_rd) ? (burst4 ? 2'h2 : 2'h1) : 2'h0;
   wire logic [1:0] launch_sub = (cq_rise && launch_any) ? 2'h1 : 2'h0;
   wire logic [4:0] issue_pairs = take_rd ? rd_pairs : 5'h00;
   wire logic [4:0] done_pairs = push_valid ? 5'h01 : 5'h00;

   // ----------------------------------------------------------------
   // read latency tracking
   // ----------------------------------------------------------------
   // echo clocks run free, so only edges that line up with an issued read carry data
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         launch_cnt <= '0;
         rd_pipe <= '0;
         word_live <= 1'b0;
         pending <= '0;
      end else begin
         launch_cnt <= launch_cnt + launch_add - launch_sub;
         pending <= pending + issue_pairs - done_pairs;
         if (cq_rise) begin
            rd_pipe <= pipe_shifted;
            word_live <= pipe_shifted[RD_LAT_EDGES-1];
         end
      end
   end

   // ----------------------------------------------------------------
   // word capture and pairing
   // ----------------------------------------------------------------
   // sample one cycle after the detected edge, clear of the data transition
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         cap_rise <= 1'b0;
         cap_fall <= 1'b0;
         have_lo <= 1'b0;
         lo_word <= '0;
         push_valid <= 1'b0;
         push_data <= '0;
      end else begin
         cap_rise <= cq_rise;
         cap_fall <= cqn_rise;
         push_valid <= cap_fall && have_lo;
         if (cap_rise && word_live) begin
            lo_word <= q_s2;
            have_lo <= 1'b1;
         end else if (cap_fall && have_lo) begin
            push_data <= {q_s2, lo_word};
            have_lo <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // read buffer and user output stage
   // ----------------------------------------------------------------
   wire logic out_load = fifo_out_valid && (!rd_valid_out || rd_ready_in);

   pair_fifo #(
      .WIDTH(PAIR_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rd_fifo (
      .clk_in(sys_clk_in),
      .rst_in(rst_in),
      .in_valid_in(push_valid),
      .in_ready_out(fifo_in_ready),
      .in_data_in(push_data),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(out_load),
      .out_data_out(fifo_out_data),
      .level_out(fifo_level)
   );

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         rd_valid_out <= 1'b0;
         rd_data_out <= '0;
      end else if (out_load) begin
         rd_valid_out <= 1'b1;
         rd_data_out <= fifo_out_data;
      end else if (rd_ready_in) begin
         rd_valid_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_k_rise_in_two;
      ##2 $rose(mem_k_out);
   endsequence

   sequence s_k_shape;
      mem_k_out[*4] ##1 !mem_k_out[*4] ##1 mem_k_out;
   endsequence

   sequence s_both_selected;
      ##2 (!mem_rd_sel_n_out && !mem_wr_sel_n_out);
   endsequence

   AST_K_SHAPE: assert property ($rose(mem_k_out) |-> s_k_shape)
      else $error("memory clock K does not hold four high, four low");
   AST_KN_INV: assert property (mem_k_n_out == ~mem_k_out)
      else $error("Kn is not the inverse of K");
   AST_CN_INV: assert property (mem_c_n_out == ~mem_c_out)
      else $error("Cn is not the inverse of C");
   AST_SINGLE_C_IDLE: assert property ($stable(multi) && !multi |-> !mem_c_out)
      else $error("C toggles in single-clock mode");
   AST_MULTI_C_DRIVEN: assert property ($stable(multi) && multi |-> mem_c_out == mem_k_out)
      else $error("C does not follow K in multi-clock mode");
   AST_WR_CENTER: assert property ($changed(mem_d_out) |-> ##2 $changed(mem_k_out))
      else $error("write data not a quarter period ahead of a K edge");
   AST_RD_ADDR_K: assert property (!burst4 && $fell(mem_rd_sel_n_out) |-> s_k_rise_in_two)
      else $error("burst-of-two read address not set before K rise");
   AST_WR_ADDR_KN: assert property ($past(launch_b) && !burst4 && !mem_wr_sel_n_out
                                    |-> mem_addr_out == $past(wr_addr_hold) ##2 $rose(mem_k_n_out))
      else $error("burst-of-two write address not set before Kn rise");
   AST_B4_ADDR_K: assert property (burst4 && $changed(mem_addr_out) |-> s_k_rise_in_two)
      else $error("burst-of-four address change not aligned to K rise");
   AST_CONCURRENT: assert property (decide && rd_req_in && wr_req_in && !burst4 && rd_room
                                    |-> s_both_selected)
      else $error("read and write not issued together");
   AST_PUSH_ROOM: assert property (push_valid |-> fifo_in_ready)
      else $error("read pair pushed into a full buffer");
   AST_PAIR_PUSH: assert property (cap_fall && have_lo |=> push_valid && push_data[DATA_W-1:0] == $past(lo_word))
      else $error("captured rise word not paired on the falling echo edge");
   AST_RATE: assert property (MEM_CLK_KHZ <= (gen2 ? GEN2_MAX_KHZ : GEN1_MAX_KHZ))
      else $error("memory clock above the generation limit");
endmodule : quad_rate_sram_port
`default_nettype wire

//--- sim/qdr_sram_model.sv
// behavioural quad-rate sram on the far side of the port: array, read pipe, echo clocks
// assumes its mode inputs match the controller's and stay put while traffic runs
`timescale 1ns/1ps
`default_nettype none
module qdr_sram_model
   import qdr_port_pkg::*;
#(
   parameter time TCO = 4ns
) (
   input wire logic burst4_in,
   input wire logic multi_clock_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic rd_sel_n_in,
   input wire logic wr_sel_n_in,
   input wire logic [DATA_W-1:0] d_in,
   input wire logic k_in,
   input wire logic k_n_in,
   input wire logic c_in,
   input wire logic c_n_in,
   output logic [DATA_W-1:0] q_out,
   output logic cq_out,
   output logic cq_n_out
);
   logic [DATA_W-1:0] mem [int];
   logic [DATA_W-1:0] wr_word [4];
   logic [ADDR_W-1:0] wr_addr;
   int rd_pipe[$];
   int wr_beat = 0;
   int cur = -1;
   wire logic out_clk = multi_clock_in ? c_in : k_in;
   wire logic out_clk_n = multi_clock_in ? c_n_in : k_n_in;

   function automatic logic [DATA_W-1:0] rd_word(input int i);
      return mem.exists(i) ? mem[i] : DATA_W'(~i);
   endfunction : rd_word

   initial begin
      q_out = '0;
      cq_out = 1'b0;
      cq_n_out = 1'b1;
   end

   // ----------------------------------------------------------------
   // read side: one memory cycle of latency, echo edge-aligned with q
   // ----------------------------------------------------------------
   always @(out_clk) begin
      cq_out <= #TCO out_clk;
      cq_n_out <= #TCO ~out_clk;
   end
   always @(posedge out_clk) begin
      cur = (rd_pipe.size() > 0) ? rd_pipe.pop_front() : -1;
      // idle bus toggles so a stale word is never mistaken for data
      q_out <= #TCO (cur >= 0) ? rd_word(cur) : ~q_out;
   end
   always @(posedge out_clk_n) begin
      q_out <= #TCO (cur >= 0) ? rd_word(cur + 1) : ~q_out;
   end
   always @(posedge k_in) begin
      // settle past the pop above so latency never depends on process order
      #1;
      if (!rd_sel_n_in) begin
         rd_pipe.push_back(int'(addr_in) * 4);
         if (burst4_in) begin
            rd_pipe.push_back(int'(addr_in) * 4 + 2);
         end
      end
   end

   // ----------------------------------------------------------------
   // write side: words taken on k and kn rises
   // ----------------------------------------------------------------
   always @(posedge k_in) begin
      if (wr_beat == 2) begin
         wr_word[2] = d_in;
         wr_beat = 3;
      end else if (!wr_sel_n_in) begin
         wr_word[0] = d_in;
         wr_addr = addr_in;
         wr_beat = 1;
      end
   end
   always @(posedge k_n_in) begin
      if (wr_beat == 1 || wr_beat == 3) begin
         wr_word[wr_beat] = d_in;
         if (!burst4_in) begin
            wr_addr = addr_in;
         end
         if (wr_beat == 3 || !burst4_in) begin
            for (int i = 0; i <= wr_beat; i++) mem[int'(wr_addr) * 4 + i] = wr_word[i];
         end
         wr_beat = (wr_beat == 1 && burst4_in) ? 2 : 0;
      end
   end
endmodule : qdr_sram_model
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench: controller against the behavioural memory model
// assumes the controller's eight-cycle memory clock and its request handshake
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import qdr_port_pkg::*;
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic burst4 = 1'b0, multi = 1'b0, gen2 = 1'b0, rd_req = 1'b0, wr_req = 1'b0, rd_ready = 1'b1;
   logic [ADDR_W-1:0] rd_addr = '0, wr_addr = '0, mem_addr;
   logic [WORDS_PER_WRITE*DATA_W-1:0] wr_data = '0;
   logic rd_ack, wr_ack, rd_valid, rd_sel_n, wr_sel_n, k, k_n, c, c_n, cq, cq_n, k_prev;
   logic [PAIR_W-1:0] rd_data;
   logic [DATA_W-1:0] mem_d, mem_q;
   logic [PAIR_W-1:0] exp_q[$], got_q[$];
   int fail_count = 0;
   int num_checks = 0;
   int since = 0;
   int kcnt = 0;

   quad_rate_sram_port i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .burst4_mode_in(burst4),
      .multi_clock_in(multi), .gen2_in(gen2), .rd_req_in(rd_req), .rd_addr_in(rd_addr), .rd_ack_out(rd_ack),
      .wr_req_in(wr_req), .wr_addr_in(wr_addr), .wr_data_in(wr_data), .wr_ack_out(wr_ack),
      .rd_data_out(rd_data), .rd_valid_out(rd_valid), .rd_ready_in(rd_ready), .mem_addr_out(mem_addr),
      .mem_rd_sel_n_out(rd_sel_n), .mem_wr_sel_n_out(wr_sel_n), .mem_d_out(mem_d), .mem_k_out(k),
      .mem_k_n_out(k_n), .mem_c_out(c), .mem_c_n_out(c_n), .mem_q_in(mem_q), .mem_cq_in(cq),
      .mem_cq_n_in(cq_n));
   qdr_sram_model i_mem (.burst4_in(burst4), .multi_clock_in(multi), .addr_in(mem_addr),
      .rd_sel_n_in(rd_sel_n), .wr_sel_n_in(wr_sel_n), .d_in(mem_d), .k_in(k), .k_n_in(k_n), .c_in(c),
      .c_n_in(c_n), .q_out(mem_q), .cq_out(cq), .cq_n_out(cq_n));

   initial begin
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [PAIR_W-1:0] exp, input logic [PAIR_W-1:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test

   function automatic logic [WORDS_PER_WRITE*DATA_W-1:0] words(input logic [ADDR_W-1:0] a);
      for (int i = 0; i < WORDS_PER_WRITE; i++) words[i*DATA_W +: DATA_W] = {a[15:0], 2'(i)} ^ 18'h2A5A5;
   endfunction : words

   task automatic reset_dut(input logic b4, input logic mc, input logic g2);
      @(negedge sys_clk_in);
      rst_in = 1'b1;
      burst4 = b4;
      multi = mc;
      gen2 = g2;
      repeat (5) @(negedge sys_clk_in);
      chk("pins in reset", 36'h17, {30'h0, k, k_n, c, c_n, rd_sel_n, wr_sel_n});
      rst_in = 1'b0;
      repeat (6) @(negedge sys_clk_in);
   endtask : reset_dut

   task automatic issue(input logic rd, input logic wr, input logic [ADDR_W-1:0] ra, input logic [ADDR_W-1:0] wa);
      logic [WORDS_PER_WRITE*DATA_W-1:0] w;
      @(negedge sys_clk_in);
      rd_req = rd;
      wr_req = wr;
      rd_addr = ra;
      wr_addr = wa;
      wr_data = words(wa);
      w = words(ra);
      if (rd) exp_q.push_back(w[PAIR_W-1:0]);
      if (rd && burst4) exp_q.push_back(w[2*PAIR_W-1:PAIR_W]);
   endtask : issue

   task automatic wait_acks(input int limit);
      for (int n = 0; n < limit && (rd_req || wr_req); n++) begin
         @(negedge sys_clk_in);
         if (rd_ack === 1'b1) rd_req = 1'b0;
         if (wr_ack === 1'b1) wr_req = 1'b0;
      end
   endtask : wait_acks

   task automatic op(input logic rd, input logic wr, input logic [ADDR_W-1:0] ra, input logic [ADDR_W-1:0] wa);
      issue(rd, wr, ra, wa);
      wait_acks(80);
      chk("request taken", 36'h0, {34'h0, rd_req, wr_req});
      if (rd_req || wr_req) end_of_test();
   endtask : op

   task automatic drain();
      for (int n = 0; n < 400 && got_q.size() < exp_q.size(); n++) @(negedge sys_clk_in);
      repeat (20) @(negedge sys_clk_in);
      chk("pair count", PAIR_W'(exp_q.size()), PAIR_W'(got_q.size()));
      if (got_q.size() < exp_q.size()) end_of_test();
      while (exp_q.size() > 0) chk("read pair", exp_q.pop_front(), got_q.pop_front());
      got_q.delete();
   endtask : drain

   // ----------------------------------------------------------------
   // pin watch and output collection
   // ----------------------------------------------------------------
   always @(posedge sys_clk_in) if (rd_valid === 1'b1 && rd_ready === 1'b1) got_q.push_back(rd_data);

   always @(negedge sys_clk_in) begin
      since = rst_in ? 0 : since + 1;
      if (since > 8) begin
         chk("k complement", {35'h0, ~k}, {35'h0, k_n});
         chk("c pair", {34'h0, (multi ? {k, ~k} : 2'b01)}, {34'h0, c, c_n});
      end
      if (since > 16 && k && !k_prev) chk("k period", PAIR_W'(K_DIV), PAIR_W'(kcnt));
      kcnt = (k && !k_prev) ? 1 : kcnt + 1;
      k_prev = k;
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic s_mode(input logic b4, input logic mc, input logic g2);
      reset_dut(b4, mc, g2);
      op(1'b0, 1'b1, '0, 18'h00011);
      op(1'b0, 1'b1, '0, 18'h3FFFF);
      op(1'b1, 1'b1, 18'h00011, 18'h20000);
      op(1'b1, 1'b0, 18'h3FFFF, '0);
      op(1'b1, 1'b0, 18'h20000, '0);
      drain();
   endtask : s_mode

   task automatic s_fifo();
      reset_dut(1'b0, 1'b0, 1'b1);
      for (int i = 0; i < 18; i++) op(1'b0, 1'b1, '0, ADDR_W'(i + 64));
      @(negedge sys_clk_in);
      rd_ready = 1'b0;
      // output stage holds one pair on top of the sixteen the buffer may commit
      for (int i = 0; i < 17; i++) op(1'b1, 1'b0, ADDR_W'(i + 64), '0);
      issue(1'b1, 1'b0, 18'h00051, '0);
      wait_acks(48);
      chk("read held back", 36'h1, {35'h0, rd_req});
      rd_ready = 1'b1;
      wait_acks(200);
      chk("held read taken", 36'h0, {35'h0, rd_req});
      if (rd_req) end_of_test();
      drain();
   endtask : s_fifo

   initial begin
      s_mode(1'b0, 1'b0, 1'b0);
      s_mode(1'b1, 1'b0, 1'b1);
      s_mode(1'b0, 1'b1, 1'b1);
      s_mode(1'b1, 1'b1, 1'b1);
      s_fifo();
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
